// ---- bdmac_pkg.sv ----
// Operation
// - Read-multiple set: read bursts use command 1100
// - Read-multiple clear: read bursts use command 0110
// - Nonzero interval re-polls suspended transmit descriptor
// - Codes 000-011: off, 200us, 800us, 1.6ms
// - Codes 100-111: 12.8, 25.6, 51.2, 102.4us
// - Bursts stop at 8/16/32 doubleword boundaries
// - Zero length: burst limited by FIFO and boundary only
// - Nonzero length caps burst; legal 0,1,2,4,8,16,32
// - Soft reset bit self-clears, starts internal reset
// - Any reset restores register defaults
`default_nettype none
package bdmac_pkg;

    localparam logic [7:0]  SYSCTRL_OFFSET    = 8'h00;
    localparam logic [3:0]  CMD_MEM_READ      = 4'h6;
    localparam logic [3:0]  CMD_MEM_READ_MULT = 4'hC;

    localparam int          READ_MULT_BIT     = 21;
    localparam int          POLL_LSB          = 17;
    localparam int          POLL_MSB          = 19;
    localparam int          ALIGN_LSB         = 14;
    localparam int          ALIGN_MSB         = 15;
    localparam int          BLEN_LSB          = 8;
    localparam int          BLEN_MSB          = 13;
    localparam int          SOFT_RESET_BIT    = 0;

    localparam logic [2:0]  POLL_OFF          = 3'h0;
    localparam logic [1:0]  ALIGN_NONE        = 2'h0;
    localparam logic [1:0]  ALIGN_8           = 2'h1;
    localparam logic [1:0]  ALIGN_16          = 2'h2;
    localparam logic [6:0]  DW_8              = 7'h08;
    localparam logic [6:0]  DW_16             = 7'h10;
    localparam logic [6:0]  DW_32             = 7'h20;

    // Times in ns as printed, clock period in ns
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          T200US_NS         = 200000;
    localparam int          T800US_NS         = 800000;
    localparam int          T1600US_NS        = 1600000;
    localparam int          T12US8_NS         = 12800;
    localparam int          T25US6_NS         = 25600;
    localparam int          T51US2_NS         = 51200;
    localparam int          T102US4_NS        = 102400;
    localparam int          T200US_CYC        = T200US_NS / CLK_PERIOD_NS;
    localparam int          T800US_CYC        = T800US_NS / CLK_PERIOD_NS;
    localparam int          T1600US_CYC       = T1600US_NS / CLK_PERIOD_NS;
    localparam int          T12US8_CYC        = T12US8_NS / CLK_PERIOD_NS;
    localparam int          T25US6_CYC        = T25US6_NS / CLK_PERIOD_NS;
    localparam int          T51US2_CYC        = T51US2_NS / CLK_PERIOD_NS;
    localparam int          T102US4_CYC       = T102US4_NS / CLK_PERIOD_NS;
    localparam int          POLL_CNT_W        = 18;

    // Internal reset length, kept well under the host's 32-clock wait
    localparam logic [4:0]  SOFT_RESET_CYC    = 5'h10;

    typedef struct packed {
        logic       readMultiple;
        logic [2:0] txPollInterval;
        logic [1:0] burstBoundaryAlign;
        logic [5:0] burstLengthLimit;
    } bdmac_ctrl_type;

    localparam bdmac_ctrl_type CTRL_RESET = '{1'b0, 3'h0, 2'h0, 6'h00};

    typedef enum logic [1:0] {
        SR_IDLE   = 2'b01,
        SR_ACTIVE = 2'b10
    } bdmac_sr_state_type;

endpackage : bdmac_pkg
`default_nettype wire

// ---- bdmac_poll_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
module bdmac_poll_timer #(
    parameter int P200US  = bdmac_pkg::T200US_CYC,
    parameter int P800US  = bdmac_pkg::T800US_CYC,
    parameter int P1600US = bdmac_pkg::T1600US_CYC,
    parameter int P12US8  = bdmac_pkg::T12US8_CYC,
    parameter int P25US6  = bdmac_pkg::T25US6_CYC,
    parameter int P51US2  = bdmac_pkg::T51US2_CYC,
    parameter int P102US4 = bdmac_pkg::T102US4_CYC
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [2:0] txPollInterval,
    input  wire logic       txSuspended,
    output logic            txPollReq
);
    localparam int W = bdmac_pkg::POLL_CNT_W;

    logic [W-1:0] count_q;
    logic [W-1:0] count_d;
    logic         pulse_q;
    logic         pulse_d;

    function automatic logic [W-1:0] pollTarget(input logic [2:0] code);
        unique case (code)
            3'h1:    pollTarget = W'(P200US);
            3'h2:    pollTarget = W'(P800US);
            3'h3:    pollTarget = W'(P1600US);
            3'h4:    pollTarget = W'(P12US8);
            3'h5:    pollTarget = W'(P25US6);
            3'h6:    pollTarget = W'(P51US2);
            3'h7:    pollTarget = W'(P102US4);
            default: pollTarget = '0;
        endcase
    endfunction : pollTarget

    always_comb begin
        count_d = '0;
        pulse_d = 1'b0;
        // Counting restarts whenever the suspension ends or polling is off
        if (txSuspended && txPollInterval != bdmac_pkg::POLL_OFF) begin
            if (count_q >= pollTarget(txPollInterval) - W'(1)) begin
                pulse_d = 1'b1;
            end else begin
                count_d = count_q + W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            count_q <= '0;
            pulse_q <= 1'b0;
        end else begin
            count_q <= count_d;
            pulse_q <= pulse_d;
        end
    end

    assign txPollReq = pulse_q;
endmodule : bdmac_poll_timer
`default_nettype wire

// ---- bdmac_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module bdmac_top #(
    parameter int P200US  = bdmac_pkg::T200US_CYC,
    parameter int P800US  = bdmac_pkg::T800US_CYC,
    parameter int P1600US = bdmac_pkg::T1600US_CYC,
    parameter int P12US8  = bdmac_pkg::T12US8_CYC,
    parameter int P25US6  = bdmac_pkg::T25US6_CYC,
    parameter int P51US2  = bdmac_pkg::T51US2_CYC,
    parameter int P102US4 = bdmac_pkg::T102US4_CYC
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic [3:0]  regByteEn,
    output logic      [31:0] regRdData,
    output logic             regRdValid,
    input  wire logic        txSuspended,
    output logic             txPollReq,
    input  wire logic        burstReq,
    input  wire logic        burstIsRead,
    input  wire logic [5:0]  burstAddrDw,
    input  wire logic [6:0]  fifoDw,
    output logic             burstGo,
    output logic      [3:0]  burstCmd,
    output logic      [6:0]  burstDw,
    output logic             devResetOut
);

    ////////////////////////////////////////////////////////////////////////////
    // Register write, soft reset sequencer

    bdmac_pkg::bdmac_ctrl_type     ctrl_q;
    bdmac_pkg::bdmac_ctrl_type     ctrl_d;
    bdmac_pkg::bdmac_sr_state_type srState_q;
    bdmac_pkg::bdmac_sr_state_type srState_d;
    logic [4:0]                    srCount_q;
    logic [4:0]                    srCount_d;
    logic                          devReset_q;
    logic                          devReset_d;
    logic                          hit;
    logic [31:0]                   wrMerged;

    always_comb begin
        hit      = (regAddr == bdmac_pkg::SYSCTRL_OFFSET);
        wrMerged = '0;
        for (int i = 0; i < 4; i++) begin
            wrMerged[i*8 +: 8] = regByteEn[i] ? regWrData[i*8 +: 8] : 8'h00;
        end
    end

    always_comb begin
        ctrl_d     = ctrl_q;
        srState_d  = srState_q;
        srCount_d  = srCount_q;
        devReset_d = 1'b0;
        unique case (srState_q)
            bdmac_pkg::SR_IDLE: begin
                if (regWrEn && hit) begin
                    // Reserved positions are not stored, so stray ones are harmless
                    if (regByteEn[2]) begin
                        ctrl_d.readMultiple   = wrMerged[bdmac_pkg::READ_MULT_BIT];
                        ctrl_d.txPollInterval = wrMerged[bdmac_pkg::POLL_MSB:bdmac_pkg::POLL_LSB];
                    end
                    if (regByteEn[1]) begin
                        ctrl_d.burstBoundaryAlign = wrMerged[bdmac_pkg::ALIGN_MSB:bdmac_pkg::ALIGN_LSB];
                        ctrl_d.burstLengthLimit   = wrMerged[bdmac_pkg::BLEN_MSB:bdmac_pkg::BLEN_LSB];
                    end
                    if (regByteEn[0] && wrMerged[bdmac_pkg::SOFT_RESET_BIT]) begin
                        srState_d  = bdmac_pkg::SR_ACTIVE;
                        srCount_d  = bdmac_pkg::SOFT_RESET_CYC;
                        ctrl_d     = bdmac_pkg::CTRL_RESET;
                        devReset_d = 1'b1;
                    end
                end
            end
            bdmac_pkg::SR_ACTIVE: begin
                // Writes during the internal reset are dropped; host must wait
                ctrl_d     = bdmac_pkg::CTRL_RESET;
                devReset_d = 1'b1;
                srCount_d  = srCount_q - 5'h01;
                if (srCount_q == 5'h01) begin
                    srState_d  = bdmac_pkg::SR_IDLE;
                    devReset_d = 1'b0;
                end
            end
            default: begin
                srState_d = bdmac_pkg::SR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_q     <= bdmac_pkg::CTRL_RESET;
            srState_q  <= bdmac_pkg::SR_IDLE;
            srCount_q  <= '0;
            devReset_q <= 1'b0;
        end else begin
            ctrl_q     <= ctrl_d;
            srState_q  <= srState_d;
            srCount_q  <= srCount_d;
            devReset_q <= devReset_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read

    logic [31:0] rdData_q;
    logic [31:0] rdData_d;
    logic        rdValid_q;
    logic        rdValid_d;

    always_comb begin
        rdData_d  = '0;
        rdValid_d = regRdEn;
        if (regRdEn && hit) begin
            rdData_d[bdmac_pkg::READ_MULT_BIT]                    = ctrl_q.readMultiple;
            rdData_d[bdmac_pkg::POLL_MSB:bdmac_pkg::POLL_LSB]     = ctrl_q.txPollInterval;
            rdData_d[bdmac_pkg::ALIGN_MSB:bdmac_pkg::ALIGN_LSB]   = ctrl_q.burstBoundaryAlign;
            rdData_d[bdmac_pkg::BLEN_MSB:bdmac_pkg::BLEN_LSB]     = ctrl_q.burstLengthLimit;
            rdData_d[bdmac_pkg::SOFT_RESET_BIT]                   = devReset_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdData_q  <= '0;
            rdValid_q <= 1'b0;
        end else begin
            rdData_q  <= rdData_d;
            rdValid_q <= rdValid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst sizing and command

    logic       go_q;
    logic       go_d;
    logic [3:0] cmd_q;
    logic [3:0] cmd_d;
    logic [6:0] dw_q;
    logic [6:0] dw_d;
    logic [6:0] boundaryDw;
    logic [6:0] toBoundary;
    logic [6:0] limit;

    always_comb begin
        unique case (ctrl_q.burstBoundaryAlign)
            bdmac_pkg::ALIGN_8:  boundaryDw = bdmac_pkg::DW_8;
            bdmac_pkg::ALIGN_16: boundaryDw = bdmac_pkg::DW_16;
            default:             boundaryDw = bdmac_pkg::DW_32;
        endcase
        toBoundary = boundaryDw - (7'({1'b0, burstAddrDw}) & (boundaryDw - 7'h01));
        limit = fifoDw;
        // Alignment code 00 (ALIGN_NONE) means no boundary is enforced
        if (ctrl_q.burstBoundaryAlign != bdmac_pkg::ALIGN_NONE && toBoundary < limit) begin
            limit = toBoundary;
        end
        // Illegal nonzero lengths are still honoured as a plain cap
        if (ctrl_q.burstLengthLimit != 6'h00 && 7'(ctrl_q.burstLengthLimit) < limit) begin
            limit = 7'(ctrl_q.burstLengthLimit);
        end
        go_d  = burstReq && !devReset_q && limit != 7'h00;
        dw_d  = burstReq ? limit : dw_q;
        cmd_d = cmd_q;
        if (burstReq) begin
            if (!burstIsRead) begin
                cmd_d = cmd_q;
            end else if (ctrl_q.readMultiple) begin
                cmd_d = bdmac_pkg::CMD_MEM_READ_MULT;
            end else begin
                cmd_d = bdmac_pkg::CMD_MEM_READ;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            go_q  <= 1'b0;
            cmd_q <= bdmac_pkg::CMD_MEM_READ;
            dw_q  <= '0;
        end else begin
            go_q  <= go_d;
            cmd_q <= cmd_d;
            dw_q  <= dw_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Automatic transmit poll

    bdmac_poll_timer #(
        .P200US  (P200US),
        .P800US  (P800US),
        .P1600US (P1600US),
        .P12US8  (P12US8),
        .P25US6  (P25US6),
        .P51US2  (P51US2),
        .P102US4 (P102US4)
    ) u_poll (
        .clk            (clk),
        .rstn           (rstn && !devReset_q),
        .txPollInterval (ctrl_q.txPollInterval),
        .txSuspended    (txSuspended),
        .txPollReq      (txPollReq)
    );

    assign regRdData   = rdData_q;
    assign regRdValid  = rdValid_q;
    assign burstGo     = go_q;
    assign burstCmd    = cmd_q;
    assign burstDw     = dw_q;
    assign devResetOut = devReset_q;
endmodule : bdmac_top
`default_nettype wire

// ---- bdmac_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module bdmac_chk (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        regWrEn,
    input wire logic        regRdEn,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWrData,
    input wire logic [3:0]  regByteEn,
    input wire logic [31:0] regRdData,
    input wire logic        regRdValid,
    input wire logic        txSuspended,
    input wire logic        txPollReq,
    input wire logic        burstReq,
    input wire logic [6:0]  fifoDw,
    input wire logic        burstGo,
    input wire logic [3:0]  burstCmd,
    input wire logic [6:0]  burstDw,
    input wire logic        devResetOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////
    property p_rdUnmapped;
        regRdEn && regAddr != 8'h00 |=> regRdValid && regRdData == 32'h0;
    endproperty
    a_rdUnmapped: assert property (p_rdUnmapped) else $error("unmapped read not zero");
    property p_cmdCode;
        burstGo |-> burstCmd inside {4'h6, 4'hC};
    endproperty
    a_cmdCode: assert property (p_cmdCode) else $error("bad burst command");
    property p_fifoCap;
        burstGo |-> burstDw <= $past(fifoDw);
    endproperty
    a_fifoCap: assert property (p_fifoCap) else $error("burst exceeds fifo");
    property p_goCause;
        burstGo |-> $past(burstReq) && burstDw != 7'h00;
    endproperty
    a_goCause: assert property (p_goCause) else $error("burst without request");
    property p_srStart;
        regWrEn && regAddr == 8'h00 && regByteEn[0] && regWrData[0] && !devResetOut |=> devResetOut;
    endproperty
    a_srStart: assert property (p_srStart) else $error("soft reset not started");
    // Internal reset must end well before the host's 32-clock wait
    property p_srLen;
        $rose(devResetOut) |-> devResetOut [*8] ##1 devResetOut [*8] ##1 !devResetOut;
    endproperty
    a_srLen: assert property (p_srLen) else $error("soft reset length wrong");
    property p_srQuiet;
        devResetOut && $past(devResetOut) |-> !burstGo;
    endproperty
    a_srQuiet: assert property (p_srQuiet) else $error("burst during soft reset");
    property p_pollPulse;
        txPollReq |-> $past(txSuspended) && $past(txSuspended, 2) ##1 !txPollReq;
    endproperty
    a_pollPulse: assert property (p_pollPulse) else $error("poll pulse wrong");
endmodule : bdmac_chk
`default_nettype wire

// ---- bdmac_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module bdmac_mem_model (
    input  wire logic       clk,
    input  wire logic       burstGo,
    input  wire logic [3:0] burstCmd,
    input  wire logic [6:0] burstDw,
    output var int          burstCount,
    output var logic        cmdBad
);
    initial begin
        burstCount = 0;
        cmdBad = 1'b0;
    end
    // Bridge decodes only the two read commands; anything else is a fault
    always @(posedge clk) begin
        if (burstGo === 1'b1) begin
            burstCount <= burstCount + 1;
            if (burstCmd !== 4'h6 && burstCmd !== 4'hC) cmdBad <= 1'b1;
        end
    end
endmodule : bdmac_mem_model
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int PER [8] = '{0, 20, 40, 60, 4, 6, 8, 10};
    logic        clk, rstn, regWrEn, regRdEn, regRdValid, txSuspended, txPollReq;
    logic        burstReq, burstIsRead, burstGo, devResetOut, cmdBad;
    logic [7:0]  regAddr;
    logic [31:0] regWrData, regRdData, rd;
    logic [3:0]  regByteEn, burstCmd;
    logic [5:0]  burstAddrDw;
    logic [6:0]  fifoDw, burstDw;
    int          burstCount, badCount, samplesChecked;
    // Short poll counts keep the run small; expectations use the same table
    bdmac_top #(.P200US(PER[1]), .P800US(PER[2]), .P1600US(PER[3]), .P12US8(PER[4]),
        .P25US6(PER[5]), .P51US2(PER[6]), .P102US4(PER[7])) DUT (.clk(clk), .rstn(rstn),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
        .regByteEn(regByteEn), .regRdData(regRdData), .regRdValid(regRdValid),
        .txSuspended(txSuspended), .txPollReq(txPollReq), .burstReq(burstReq),
        .burstIsRead(burstIsRead), .burstAddrDw(burstAddrDw), .fifoDw(fifoDw), .burstGo(burstGo),
        .burstCmd(burstCmd), .burstDw(burstDw), .devResetOut(devResetOut));
    bdmac_mem_model mem (.clk(clk), .burstGo(burstGo), .burstCmd(burstCmd), .burstDw(burstDw),
        .burstCount(burstCount), .cmdBad(cmdBad));
    ////////////////////////////////////////////////////////////////
    task automatic testDone();
        if (badCount == 0 && samplesChecked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : testDone
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            badCount++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check
    task automatic regWr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        regByteEn <= be;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask : regWr
    task automatic regRd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        check(regRdValid, 32'h1);
        d = regRdData;
    endtask : regRd
    task automatic burst(input logic r, input logic [5:0] a, input logic [6:0] f, input logic [6:0] e);
        int n0;
        n0 = burstCount;
        @(posedge clk);
        burstReq <= 1'b1;
        burstIsRead <= r;
        burstAddrDw <= a;
        fifoDw <= f;
        @(posedge clk);
        burstReq <= 1'b0;
        #1;
        check(burstGo, {31'h0, e != 7'h00});
        check(burstDw, e);
        @(posedge clk);
        #1;
        check(burstCount - n0, {31'h0, e != 7'h00});
    endtask : burst
    task automatic waitPoll(input int lim, input bit must, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (txPollReq !== 1'b1 && n < lim);
        if (must && txPollReq !== 1'b1) begin
            check(32'h0, 32'h1);
            testDone();
        end
    endtask : waitPoll
    ////////////////////////////////////////////////////////////////
    task automatic sFields();
        regRd(8'h00, rd);
        check(rd, 32'h0);
        check(burstCmd, 32'h6);
        regWr(8'h00, 32'h002EE000, 4'hF);
        regRd(8'h00, rd);
        check(rd, 32'h002EE000);
        regWr(8'h00, 32'h0, 4'h2);
        regWr(8'h08, 32'hFFFFFFFE, 4'hF);
        regRd(8'h00, rd);
        check(rd, 32'h002E0000);
        regRd(8'h08, rd);
        check(rd, 32'h0);
    endtask : sFields
    task automatic sCmd();
        regWr(8'h00, 32'h00200000, 4'hF);
        burst(1'b1, 6'h00, 7'h08, 7'h08);
        check(burstCmd, 32'hC);
        regWr(8'h00, 32'h0, 4'hF);
        burst(1'b0, 6'h00, 7'h08, 7'h08);
        check(burstCmd, 32'hC);
        burst(1'b1, 6'h00, 7'h08, 7'h08);
        check(burstCmd, 32'h6);
        check(cmdBad, 32'h0);
    endtask : sCmd
    task automatic sSize();
        int lens [6] = '{1, 2, 4, 8, 16, 32};
        for (int a = 1; a < 4; a++) begin
            regWr(8'h00, 32'(a) << 14, 4'hF);
            burst(1'b1, 6'h05, 7'h40, 7'((8 << (a - 1)) - 5));
        end
        regWr(8'h00, 32'h0, 4'hF);
        burst(1'b1, 6'h05, 7'h40, 7'h40);
        burst(1'b0, 6'h05, 7'h00, 7'h00);
        foreach (lens[i]) begin
            regWr(8'h00, 32'(lens[i]) << 8, 4'hF);
            burst(1'b1, 6'h00, 7'h64, 7'(lens[i]));
        end
        regWr(8'h00, 32'h00004400, 4'hF);
        burst(1'b1, 6'h02, 7'h64, 7'h04);
        burst(1'b1, 6'h05, 7'h64, 7'h03);
        burst(1'b0, 6'h00, 7'h02, 7'h02);
    endtask : sSize
    task automatic sPoll();
        int first;
        int gap;
        for (int c = 0; c < 8; c++) begin
            regWr(8'h00, 32'(c) << 17, 4'hF);
            @(posedge clk);
            txSuspended <= 1'b1;
            if (c == 0) begin
                waitPoll(100, 1'b0, first);
                check(txPollReq, 32'h0);
            end else begin
                waitPoll(PER[c] + 4, 1'b1, first);
                check(first, PER[c]);
                waitPoll(PER[c] + 2, 1'b1, gap);
                if (c < 4) check(gap, PER[c]);
                else check(gap, PER[c]);
            end
            @(posedge clk);
            txSuspended <= 1'b0;
        end
    endtask : sPoll
    task automatic sReset();
        regWr(8'h00, 32'h002EE000, 4'hF);
        regWr(8'h00, 32'h00000001, 4'h1);
        @(posedge clk);
        #1;
        check(devResetOut, 32'h1);
        repeat (32) @(posedge clk);
        #1;
        check(devResetOut, 32'h0);
        regRd(8'h00, rd);
        check(rd, 32'h0);
        regWr(8'h00, 32'h002EE000, 4'hF);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        regRd(8'h00, rd);
        check(rd, 32'h0);
    endtask : sReset
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {rstn, regWrEn, regRdEn, txSuspended, burstReq, burstIsRead} = '0;
        {regAddr, regWrData, regByteEn, burstAddrDw, fifoDw} = '0;
        badCount = 0;
        samplesChecked = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        sFields();
        sCmd();
        sSize();
        sPoll();
        sReset();
        testDone();
    end
endmodule : tb_top
bind bdmac_top bdmac_chk chk (.clk(clk), .rstn(rstn), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regByteEn(regByteEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .txSuspended(txSuspended), .txPollReq(txPollReq), .burstReq(burstReq),
    .fifoDw(fifoDw), .burstGo(burstGo), .burstCmd(burstCmd), .burstDw(burstDw), .devResetOut(devResetOut));
`default_nettype wire
